// ### rtl/lpl_fifo.sv
`timescale 1ns/1ps
// Synchronous word buffer with honest full and empty
module lpl_fifo #(
	parameter int W     = 28,
	parameter int DEPTH = 8
) (
	input  wire logic   sys_clk,
	input  wire logic   resetn,
	lpl_stream_if.snk   in_s,
	lpl_stream_if.src   out_s
);
	localparam int AW = $clog2(DEPTH);

	// Depth must be a power of two for the wrap bit to work
	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("lpl_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [W-1:0] mem [DEPTH];  // Storage
	logic [AW:0]  wr_q;         // Write pointer with wrap bit
	logic [AW:0]  wr_d;
	logic [AW:0]  rd_q;         // Read pointer with wrap bit
	logic [AW:0]  rd_d;
	logic         full;
	logic         empty;
	logic         push;
	logic         pop;

	// Flags and handshakes
	always_comb
	begin
		empty = (wr_q == rd_q);
		full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
		in_s.ready  = !full;
		out_s.valid = !empty;
		out_s.data  = mem[rd_q[AW-1:0]];
		push = in_s.valid && !full;
		pop  = out_s.ready && !empty;
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
	end

	// Pointer registers
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	// Storage write
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_s.data;
	end

endmodule : lpl_fifo

// ### rtl/lpl_link_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - capture one 28-bit word each pixel clock
// - four data lanes plus forwarded clock lane
// - seven bit slots per lane per pixel
// - word is RGB 8/8/8 plus four controls
// - receiver rebuilds 28 bits from lanes
// - falling pixel clock edge samples inputs
// - transmit power-down releases all serial outputs
// - receive power-down holds parallel outputs
// - data invalid until 10 ms lock elapsed
module lpl_link_top
	import lpl_pkg::*;
#(
	parameter int LOCK_CYC = lpl_pkg::LOCK_CYCLES
) (
	input  wire logic                             sys_clk,
	input  wire logic                             resetn,
	input  wire logic [lpl_pkg::WORD_W-1:0]       parallel_pixel_inputs,
	input  wire logic                             pixel_strobe_clock_in,
	input  wire logic                             tx_low_power_request_n,
	output logic      [lpl_pkg::LANES-1:0]        serial_data_lane_outputs,
	output logic      [lpl_pkg::LANES-1:0]        serial_data_lane_oe_n,
	output logic                                  forwarded_lane_clock_out,
	output logic                                  forwarded_lane_clock_oe_n,
	output logic                                  tx_capture_ready,
	output logic                                  tx_locked,
	input  wire logic [lpl_pkg::LANES-1:0]        serial_data_lane_inputs,
	input  wire logic                             forwarded_lane_clock_in,
	input  wire logic                             rx_low_power_request_n,
	output logic      [lpl_pkg::WORD_W-1:0]       parallel_pixel_outputs,
	output logic                                  pixel_strobe_clock_out,
	output logic                                  rx_locked
);
	import lpl_pkg::*;

	initial
	begin
		if (LOCK_CYC < 1 || LOCK_CYC >= (1 << LOCK_W))
			$error("lpl_link_top: LOCK_CYC out of counter range");
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0]        pclk_s;       // Pixel clock stages
	logic [WORD_W-1:0] pdat_s1;      // Pixel data first stage
	logic [WORD_W-1:0] pdat_s2;      // Pixel data second stage
	logic [WORD_W-1:0] pdat_s3;      // Pixel data before the edge
	logic [1:0]        tpwr_s;       // Transmit power request
	logic [1:0]        rpwr_s;       // Receive power request
	logic [2:0]        lclk_s;       // Lane clock stages
	logic [LANES-1:0]  lane_s1;      // Lane data first stage
	logic [LANES-1:0]  lane_s2;      // Lane data usable stage

	// Two flops per pin, a third for edge finding
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pclk_s  <= '0;
			pdat_s1 <= '0;
			pdat_s2 <= '0;
			pdat_s3 <= '0;
			tpwr_s  <= '0;
			rpwr_s  <= '0;
			lclk_s  <= '0;
			lane_s1 <= '0;
			lane_s2 <= '0;
		end
		else
		begin
			pclk_s  <= {pclk_s[1:0], pixel_strobe_clock_in};
			pdat_s1 <= parallel_pixel_inputs;
			pdat_s2 <= pdat_s1;
			pdat_s3 <= pdat_s2;
			tpwr_s  <= {tpwr_s[0], tx_low_power_request_n};
			rpwr_s  <= {rpwr_s[0], rx_low_power_request_n};
			lclk_s  <= {lclk_s[1:0], forwarded_lane_clock_in};
			lane_s1 <= serial_data_lane_inputs;
			lane_s2 <= lane_s1;
		end
	end

	logic tx_on;     // Transmitter powered
	logic rx_on;     // Receiver powered
	logic pix_fall;  // Falling pixel clock seen
	logic lck_rise;  // Rising lane clock seen

	assign tx_on    = tpwr_s[1];
	assign rx_on    = rpwr_s[1];
	assign pix_fall = pclk_s[2] && !pclk_s[1];
	assign lck_rise = lclk_s[1] && !lclk_s[2];

	// ---------------------------------------------------------------
	// Transmit buffer
	// ---------------------------------------------------------------
	lpl_stream_if #(.W(WORD_W)) push_if ();
	lpl_stream_if #(.W(WORD_W)) pop_if ();

	lpl_fifo #(
		.W     (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.in_s    (push_if),
		.out_s   (pop_if)
	);

	logic tx_lock_q;  // Transmit lock time elapsed

	// Word held before the falling edge enters the buffer
	assign push_if.valid = pix_fall && tx_on && tx_lock_q;
	assign push_if.data  = pdat_s3;
	assign pop_if.ready  = pix_fall && tx_on && tx_lock_q;

	// ---------------------------------------------------------------
	// Transmit serializer
	// ---------------------------------------------------------------
	logic [PER_W-1:0]  tper_cnt_q, tper_cnt_d;  // Cycles since last fall
	logic [PER_W-1:0]  tper_q, tper_d;          // Measured pixel period
	logic [PER_W-1:0]  tacc_q, tacc_d;          // Slot phase accumulator
	logic [SLOT_W-1:0] tslot_q, tslot_d;        // Current slot
	logic              tact_q, tact_d;          // Frame in progress
	logic [WORD_W-1:0] tword_q, tword_d;        // Word being sent
	logic [LANES-1:0]  lout_q, lout_d;
	logic [LANES-1:0]  loe_n_q, loe_n_d;
	logic              fclk_q, fclk_d;
	logic              foe_n_q, foe_n_d;
	logic              tcap_q, tcap_d;
	logic [LOCK_W-1:0] tlock_cnt_q, tlock_cnt_d;
	logic              tx_lock_d;
	logic [PER_W-1:0]  tacc_n;

	// Next transmit state
	always_comb
	begin
		tper_cnt_d  = (&tper_cnt_q) ? tper_cnt_q : tper_cnt_q + 1'b1;
		tper_d      = tper_q;
		tacc_d      = tacc_q;
		tslot_d     = tslot_q;
		tact_d      = tact_q;
		tword_d     = tword_q;
		tacc_n      = tacc_q + PER_W'(SLOTS);
		tcap_d      = push_if.ready;
		// Lock counter restarts after power-down
		tlock_cnt_d = tlock_cnt_q;
		tx_lock_d   = tx_lock_q;
		if (!tx_on)
		begin
			tlock_cnt_d = '0;
			tx_lock_d   = 1'b0;
		end
		else if (!tx_lock_q)
		begin
			tlock_cnt_d = tlock_cnt_q + 1'b1;
			tx_lock_d   = (tlock_cnt_q == LOCK_W'(LOCK_CYC - 1));
		end
		// Frame start on each falling edge
		if (pix_fall)
		begin
			tper_cnt_d = PER_W'(1);
			tper_d     = tper_cnt_q;
			tacc_d     = '0;
			tslot_d    = '0;
			tact_d     = tx_on && tx_lock_q;
			tword_d    = pop_if.valid ? pop_if.data : '0;
		end
		// Seven slots spread over one measured period
		else if (tact_q && tacc_n >= tper_q)
		begin
			tacc_d  = tacc_n - tper_q;
			tslot_d = tslot_q + 1'b1;
			if (tslot_q == LAST_SLOT)
				tact_d = 1'b0;
		end
		else if (tact_q)
			tacc_d = tacc_n;
		// Lane drivers
		lout_d = '0;
		for (int l = 0; l < LANES; l++)
			if (tact_q)
				lout_d[l] = tword_q[lane_bit_index(l, int'(tslot_q))];
		fclk_d  = tact_q && LANE_CLK_PATTERN[tslot_q];
		loe_n_d = tx_on ? '0 : '1;
		foe_n_d = !tx_on;
		if (!tx_on)
		begin
			lout_d = '0;
			fclk_d = 1'b0;
		end
	end

	// Transmit registers
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tper_cnt_q  <= '0;
			tper_q      <= '0;
			tacc_q      <= '0;
			tslot_q     <= '0;
			tact_q      <= 1'b0;
			tword_q     <= '0;
			lout_q      <= '0;
			loe_n_q     <= '1;
			fclk_q      <= 1'b0;
			foe_n_q     <= 1'b1;
			tcap_q      <= 1'b0;
			tlock_cnt_q <= '0;
			tx_lock_q   <= 1'b0;
		end
		else
		begin
			tper_cnt_q  <= tper_cnt_d;
			tper_q      <= tper_d;
			tacc_q      <= tacc_d;
			tslot_q     <= tslot_d;
			tact_q      <= tact_d;
			tword_q     <= tword_d;
			lout_q      <= lout_d;
			loe_n_q     <= loe_n_d;
			fclk_q      <= fclk_d;
			foe_n_q     <= foe_n_d;
			tcap_q      <= tcap_d;
			tlock_cnt_q <= tlock_cnt_d;
			tx_lock_q   <= tx_lock_d;
		end
	end

	assign serial_data_lane_outputs  = lout_q;
	assign serial_data_lane_oe_n     = loe_n_q;
	assign forwarded_lane_clock_out  = fclk_q;
	assign forwarded_lane_clock_oe_n = foe_n_q;
	assign tx_capture_ready          = tcap_q;
	assign tx_locked                 = tx_lock_q;

	// ---------------------------------------------------------------
	// Receive deserializer
	// ---------------------------------------------------------------
	logic [PER_W-1:0]   rper_cnt_q, rper_cnt_d;  // Cycles since last rise
	logic [PER_W-1:0]   rper_q, rper_d;          // Measured lane clock period
	logic [PER_W+3:0]   racc_q, racc_d;          // Phase, 14 units a cycle
	logic [PER_W+3:0]   rthr_q, rthr_d;          // Next slot centre
	logic [SLOT_W-1:0]  rslot_q, rslot_d;
	logic               ract_q, ract_d;
	logic [WORD_W-1:0]  rword_q, rword_d;        // Word being assembled
	logic [WORD_W-1:0]  pout_q, pout_d;
	logic               pstb_q, pstb_d;
	logic [LOCK_W-1:0]  rlock_cnt_q, rlock_cnt_d;
	logic               rlock_q, rlock_d;
	logic [PER_W+3:0]   racc_n;

	// Next receive state
	always_comb
	begin
		rper_cnt_d  = (&rper_cnt_q) ? rper_cnt_q : rper_cnt_q + 1'b1;
		rper_d      = rper_q;
		racc_d      = racc_q;
		rthr_d      = rthr_q;
		rslot_d     = rslot_q;
		ract_d      = ract_q;
		rword_d     = rword_q;
		pout_d      = pout_q;
		pstb_d      = pstb_q;
		racc_n      = racc_q + (PER_W+4)'(2 * SLOTS);
		rlock_cnt_d = rlock_cnt_q;
		rlock_d     = rlock_q;
		if (!rx_on)
		begin
			rlock_cnt_d = '0;
			rlock_d     = 1'b0;
		end
		else if (!rlock_q)
		begin
			rlock_cnt_d = rlock_cnt_q + 1'b1;
			rlock_d     = (rlock_cnt_q == LOCK_W'(LOCK_CYC - 1));
		end
		// Rising lane clock opens a frame, first centre half a slot in
		if (lck_rise)
		begin
			rper_cnt_d = PER_W'(1);
			rper_d     = rper_cnt_q;
			racc_d     = '0;
			rthr_d     = (PER_W+4)'(rper_cnt_q);
			rslot_d    = '0;
			ract_d     = 1'b1;
		end
		else if (ract_q && racc_n >= rthr_q)
		begin
			// Sample every lane at the slot centre
			for (int l = 0; l < LANES; l++)
				rword_d[lane_bit_index(l, int'(rslot_q))] = lane_s2[l];
			racc_d  = racc_n;
			rthr_d  = rthr_q + (PER_W+4)'({rper_q, 1'b0});
			rslot_d = rslot_q + 1'b1;
			// Strobe falls mid frame, data still stable
			if (rslot_q == STROBE_SLOT && rx_on && rlock_q)
				pstb_d = 1'b0;
			if (rslot_q == LAST_SLOT)
			begin
				ract_d = 1'b0;
				// New word only with a rising strobe; a strobe still high from
				// before lock or power-down skips one word instead
				if (rx_on && rlock_q && !pstb_q)
				begin
					pout_d = rword_d;
					pstb_d = 1'b1;
				end
			end
		end
		else if (ract_q)
			racc_d = racc_n;
	end

	// Receive registers
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rper_cnt_q  <= '0;
			rper_q      <= '0;
			racc_q      <= '0;
			rthr_q      <= '0;
			rslot_q     <= '0;
			ract_q      <= 1'b0;
			rword_q     <= '0;
			pout_q      <= '0;
			pstb_q      <= 1'b0;
			rlock_cnt_q <= '0;
			rlock_q     <= 1'b0;
		end
		else
		begin
			rper_cnt_q  <= rper_cnt_d;
			rper_q      <= rper_d;
			racc_q      <= racc_d;
			rthr_q      <= rthr_d;
			rslot_q     <= rslot_d;
			ract_q      <= ract_d;
			rword_q     <= rword_d;
			pout_q      <= pout_d;
			pstb_q      <= pstb_d;
			rlock_cnt_q <= rlock_cnt_d;
			rlock_q     <= rlock_d;
		end
	end

	assign parallel_pixel_outputs = pout_q;
	assign pixel_strobe_clock_out = pstb_q;
	assign rx_locked              = rlock_q;

endmodule : lpl_link_top

// ### rtl/lpl_pkg.sv
package lpl_pkg;

	// ---------------------------------------------------------------
	// Word layout
	// ---------------------------------------------------------------
	localparam int WORD_W         = 28;  // Parallel pixel word width
	localparam int COLOR_W        = 8;   // Bits per colour
	localparam int RED_LSB        = 0;   // Red field base
	localparam int GREEN_LSB      = 8;   // Green field base
	localparam int BLUE_LSB       = 16;  // Blue field base
	localparam int LINE_SYNC_BIT  = 24;  // Line sync position
	localparam int FRAME_SYNC_BIT = 25;  // Frame sync position
	localparam int VALID_BIT      = 26;  // Pixel data valid position
	localparam int SPARE_BIT      = 27;  // Spare control position

	// ---------------------------------------------------------------
	// Link shape
	// ---------------------------------------------------------------
	localparam int LANES       = 4;        // Serial data lanes
	localparam int SLOTS       = 7;        // Bit slots per lane per pixel
	localparam int SLOT_W      = 3;        // Width of a slot index
	localparam int PER_W       = 12;       // Width of period counters
	localparam int FIFO_DEPTH  = 8;        // Words buffered on transmit
	localparam logic [SLOT_W-1:0] LAST_SLOT   = 3'h6;   // Final slot of a frame
	localparam logic [SLOT_W-1:0] STROBE_SLOT = 3'h3;   // Slot at which strobe falls
	localparam logic [SLOTS-1:0]  LANE_CLK_PATTERN = 7'h07; // Slots 0..2 high

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_KHZ           = 200000; // System clock rate
	localparam int PIX_PERIOD_MIN_NS = 25;     // Shortest pixel period
	localparam int PIX_PERIOD_MAX_NS = 50;     // Longest pixel period
	localparam int LOCK_TIME_MS      = 10;     // Multiplier lock time
	localparam int LOCK_CYCLES       = LOCK_TIME_MS * CLK_KHZ;
	localparam int LOCK_W            = 22;     // Lock counter width

	// Bit position of one lane slot inside the word
	function automatic int lane_bit_index(input int lane, input int slot);
		return lane * SLOTS + slot;
	endfunction : lane_bit_index

endpackage : lpl_pkg

// ### rtl/lpl_stream_if.sv
`timescale 1ns/1ps
// Valid/ready word stream between the link core and its buffer
interface lpl_stream_if #(
	parameter int W = 28
);
	logic         valid;  // Word offered
	logic         ready;  // Word accepted
	logic [W-1:0] data;   // Word itself

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : lpl_stream_if

// ### testbench/lpl_cable_model.sv
`timescale 1ns/1ps
// Cable from transmit pins back to receive pins
module lpl_cable_model (
	input  wire logic                      sys_clk,
	input  wire logic [lpl_pkg::LANES-1:0] lane_out,
	input  wire logic [lpl_pkg::LANES-1:0] lane_oe_n,
	input  wire logic                      clk_out,
	input  wire logic                      clk_oe_n,
	output logic      [lpl_pkg::LANES-1:0] lane_in,
	output logic                           clk_in
);
	import lpl_pkg::*;

	logic [LANES:0] last_q = '0; // Levels seen last cycle

	// Remember far-end levels
	always_ff @(posedge sys_clk)
		last_q <= {clk_in, lane_in};

	// Driven lines pass in order, released lines toggle
	always_comb
	begin
		lane_in = lane_out;
		clk_in  = clk_oe_n ? ~last_q[LANES] : clk_out;
		for (int i = 0; i < LANES; i++)
			if (lane_oe_n[i])
				lane_in[i] = ~last_q[i];
	end
endmodule : lpl_cable_model

// ### testbench/lpl_link_asserts.sv
`timescale 1ns/1ps
// Port checks of the link top
module lpl_link_asserts #(
	parameter int LOCK_CYC = lpl_pkg::LOCK_CYCLES
) (
	input wire logic                       sys_clk,
	input wire logic                       resetn,
	input wire logic [lpl_pkg::WORD_W-1:0] parallel_pixel_inputs,
	input wire logic                       pixel_strobe_clock_in,
	input wire logic                       tx_low_power_request_n,
	input wire logic [lpl_pkg::LANES-1:0]  serial_data_lane_outputs,
	input wire logic [lpl_pkg::LANES-1:0]  serial_data_lane_oe_n,
	input wire logic                       forwarded_lane_clock_out,
	input wire logic                       forwarded_lane_clock_oe_n,
	input wire logic                       tx_capture_ready,
	input wire logic                       tx_locked,
	input wire logic [lpl_pkg::LANES-1:0]  serial_data_lane_inputs,
	input wire logic                       forwarded_lane_clock_in,
	input wire logic                       rx_low_power_request_n,
	input wire logic [lpl_pkg::WORD_W-1:0] parallel_pixel_outputs,
	input wire logic                       pixel_strobe_clock_out,
	input wire logic                       rx_locked
);
	import lpl_pkg::*;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// -------------------------------------------------------
	// Cycles since each power request went high
	// -------------------------------------------------------
	logic [31:0] tx_up_q; // Transmit side
	logic [31:0] rx_up_q; // Receive side

	// Count while powered, clear on power-down
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tx_up_q <= '0;
			rx_up_q <= '0;
		end
		else
		begin
			tx_up_q <= tx_low_power_request_n ? tx_up_q + 32'h1 : '0;
			rx_up_q <= rx_low_power_request_n ? rx_up_q + 32'h1 : '0;
		end
	end

	// -------------------------------------------------------
	// Properties
	// -------------------------------------------------------
	property p_tx_release;
		!tx_low_power_request_n [*5] |-> &serial_data_lane_oe_n && forwarded_lane_clock_oe_n;
	endproperty
	a_tx_release: assert property (p_tx_release)
		else $error("serial outputs driven in power-down");

	property p_idle_low;
		forwarded_lane_clock_oe_n [*4] |->
			serial_data_lane_outputs == 4'h0 && !forwarded_lane_clock_out;
	endproperty
	a_idle_low: assert property (p_idle_low)
		else $error("released lanes not idle");

	property p_rx_hold;
		!rx_low_power_request_n [*6] |->
			$stable(parallel_pixel_outputs) && $stable(pixel_strobe_clock_out);
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("receiver outputs moved in power-down");

	property p_rx_unlocked;
		!rx_locked ##1 !rx_locked |-> $stable(parallel_pixel_outputs);
	endproperty
	a_rx_unlocked: assert property (p_rx_unlocked)
		else $error("word delivered before lock");

	property p_tx_lock_time;
		$rose(tx_locked) |-> tx_up_q >= LOCK_CYC && tx_up_q <= LOCK_CYC + 8;
	endproperty
	a_tx_lock_time: assert property (p_tx_lock_time)
		else $error("transmit lock time wrong");

	property p_rx_lock_time;
		$rose(rx_locked) |-> rx_up_q >= LOCK_CYC && rx_up_q <= LOCK_CYC + 8;
	endproperty
	a_rx_lock_time: assert property (p_rx_lock_time)
		else $error("receive lock time wrong");

	property p_word_strobe;
		$changed(parallel_pixel_outputs) |-> $rose(pixel_strobe_clock_out);
	endproperty
	a_word_strobe: assert property (p_word_strobe)
		else $error("word changed without strobe rise");

	property p_fwd_high;
		tx_locked && $rose(forwarded_lane_clock_out) |->
			(forwarded_lane_clock_out || !tx_low_power_request_n) [*8];
	endproperty
	a_fwd_high: assert property (p_fwd_high)
		else $error("lane clock high time short");

	c_capture: cover property ($fell(pixel_strobe_clock_out) && rx_locked);
	c_tx_down: cover property ($rose(forwarded_lane_clock_oe_n));
	c_rx_hold: cover property (!rx_low_power_request_n && rx_locked);
endmodule : lpl_link_asserts

bind lpl_link_top lpl_link_asserts #(.LOCK_CYC(LOCK_CYC)) u_chk (
	.sys_clk(sys_clk), .resetn(resetn), .parallel_pixel_inputs(parallel_pixel_inputs),
	.pixel_strobe_clock_in(pixel_strobe_clock_in),
	.tx_low_power_request_n(tx_low_power_request_n),
	.serial_data_lane_outputs(serial_data_lane_outputs),
	.serial_data_lane_oe_n(serial_data_lane_oe_n),
	.forwarded_lane_clock_out(forwarded_lane_clock_out),
	.forwarded_lane_clock_oe_n(forwarded_lane_clock_oe_n),
	.tx_capture_ready(tx_capture_ready), .tx_locked(tx_locked),
	.serial_data_lane_inputs(serial_data_lane_inputs),
	.forwarded_lane_clock_in(forwarded_lane_clock_in),
	.rx_low_power_request_n(rx_low_power_request_n),
	.parallel_pixel_outputs(parallel_pixel_outputs),
	.pixel_strobe_clock_out(pixel_strobe_clock_out), .rx_locked(rx_locked));

// ### testbench/tb_lvds_pixel_link_serdes.sv
`timescale 1ns/1ps
// Loopback bench for the link top
module tb_lvds_pixel_link_serdes;
	import lpl_pkg::*;

	localparam int LOCK_N = 100; // Shortened lock time
	localparam int PIX_N  = 25;  // Pixel period, 125 ns

	logic              sys_clk = 0, resetn = 0, pix_clk = 0, tx_req_n = 1, rx_req_n = 1;
	logic [WORD_W-1:0] pix_in = '0, pix_out, held;
	logic [LANES-1:0]  lane_q, lane_oe_n, lane_in;
	logic              fwd_clk, fwd_oe_n, fwd_in, cap_rdy, tx_lk, rx_lk, strobe, strobe_q, fwd_q;
	logic [WORD_W-1:0] sent_q[$]; // Words handed over
	int                num_errors = 0, n_tests = 0, n_caps, per, hi, cnt, hcnt, pcnt, wdx, lk_n;
	bit                chk_en = 0, seeded = 0;

	lpl_link_top #(.LOCK_CYC(LOCK_N)) i_dut (
		.sys_clk(sys_clk), .resetn(resetn), .parallel_pixel_inputs(pix_in),
		.pixel_strobe_clock_in(pix_clk), .tx_low_power_request_n(tx_req_n),
		.serial_data_lane_outputs(lane_q), .serial_data_lane_oe_n(lane_oe_n),
		.forwarded_lane_clock_out(fwd_clk), .forwarded_lane_clock_oe_n(fwd_oe_n),
		.tx_capture_ready(cap_rdy), .tx_locked(tx_lk), .serial_data_lane_inputs(lane_in),
		.forwarded_lane_clock_in(fwd_in), .rx_low_power_request_n(rx_req_n),
		.parallel_pixel_outputs(pix_out), .pixel_strobe_clock_out(strobe), .rx_locked(rx_lk));

	lpl_cable_model i_cable (.sys_clk(sys_clk), .lane_out(lane_q), .lane_oe_n(lane_oe_n),
		.clk_out(fwd_clk), .clk_oe_n(fwd_oe_n), .lane_in(lane_in), .clk_in(fwd_in));

	initial forever #2.5 sys_clk = ~sys_clk;

	// --------------------------------------------
	// Helpers
	// --------------------------------------------
	task automatic fail(input string m);
		num_errors++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask : fail

	task automatic check_eq(input logic [31:0] got, exp, input string m);
		n_tests++;
		if (got !== exp)
			fail(m);
	endtask : check_eq

	task automatic check_in(input int v, lo, up, input string m);
		n_tests++;
		if (v < lo || v > up)
			fail(m);
	endtask : check_in

	// Fields packed red, green, blue, controls
	function automatic logic [WORD_W-1:0] mk(input logic [7:0] r, g, b, input logic [3:0] c);
		return {c, b, g, r};
	endfunction : mk

	// Corner words first, then random ones
	function automatic logic [WORD_W-1:0] pick(input int k);
		logic [31:0] r;
		r = $urandom;
		case (k)
			0: return mk(8'h00, 8'h00, 8'h00, 4'h0);
			1: return mk(8'hff, 8'hff, 8'hff, 4'hf);
			2: return mk(8'hff, 8'h00, 8'h00, 4'h0);
			3: return mk(8'h00, 8'hff, 8'h00, 4'h0);
			4: return mk(8'h00, 8'h00, 8'hff, 4'h0);
			5, 6, 7, 8: return mk(8'h00, 8'h00, 8'h00, 4'h1 << (k - 5));
			default: return mk(r[7:0], r[15:8], r[23:16], r[27:24]);
		endcase
	endfunction : pick

	// Received word must be a recent sent one, in order
	task automatic capture(input logic [WORD_W-1:0] w);
		int i;
		n_caps++;
		if (!chk_en)
			return;
		for (i = 0; i < 4 && i < sent_q.size(); i++)
			if (sent_q[i] === w)
				break;
		n_tests++;
		// After the first capture of a stream every word must be the oldest one
		if (i == 4 || i == sent_q.size() || (n_caps > 1 && i != 0))
			fail("word lost or reordered");
		else
			repeat (i + 1) void'(sent_q.pop_front());
	endtask : capture

	// Source, capture and lane clock watch, on falling sys_clk
	always @(negedge sys_clk)
	begin
		// Seed the thread that draws the stimulus, once
		if (!seeded)
		begin
			void'($urandom(32'hc7cf05ec));
			seeded = 1;
		end
		pcnt = (pcnt == PIX_N - 1) ? 0 : pcnt + 1;
		pix_clk = (pcnt < 13);
		if (pcnt == 0)
			pix_in = pick(wdx++);
		if (pcnt == 13)
			sent_q.push_back(pix_in);
		if (strobe_q && !strobe)
			capture(pix_out);
		strobe_q = strobe;
		while (!chk_en && sent_q.size() > 4)
			void'(sent_q.pop_front());
		cnt++;
		hcnt += fwd_clk;
		if (fwd_clk && !fwd_q)
		begin
			per = cnt;
			hi = hcnt - 1;
			cnt = 0;
			hcnt = 1;
		end
		fwd_q = fwd_clk;
	end

	task automatic do_reset();
		resetn = 1'b0;
		repeat (5) @(negedge sys_clk);
		check_eq(lane_oe_n, 4'hf, "lanes driven in reset");
		check_eq({tx_lk, rx_lk, pix_out}, 30'h0, "outputs not cleared");
		resetn = 1'b1;
	endtask : do_reset

	task automatic wait_lock();
		lk_n = 0;
		while (!(tx_lk === 1'b1 && rx_lk === 1'b1) && lk_n < 400)
		begin
			@(negedge sys_clk);
			lk_n++;
		end
	endtask : wait_lock

	task automatic stream(input int n);
		repeat (5 * PIX_N) @(negedge sys_clk);
		wdx = 0;
		n_caps = 0;
		chk_en = 1;
		repeat (n * PIX_N) @(negedge sys_clk);
		chk_en = 0;
		check_in(n_caps, n - 1, n + 1, "strobe count");
		check_in(per, PIX_N - 1, PIX_N + 1, "lane clock period");
		check_in(hi, 10, 12, "lane clock high");
		check_eq(cap_rdy, 1'b1, "buffer refused");
	endtask : stream

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	// Run needs about 2400 cycles
	initial
	begin
		#100us;
		fail("watchdog expired");
		tally_and_finish();
	end

	initial
	begin
		do_reset();
		wait_lock();
		check_in(lk_n, LOCK_N, LOCK_N + 10, "lock time");
		stream(40);
		$display("test stream done");
		rx_req_n = 1'b0;
		repeat (10) @(negedge sys_clk);
		held = pix_out;
		repeat (4 * PIX_N) @(negedge sys_clk);
		check_eq(pix_out, held, "output moved");
		rx_req_n = 1'b1;
		$display("test rx power-down done");
		tx_req_n = 1'b0;
		repeat (5) @(negedge sys_clk);
		check_eq({fwd_oe_n, lane_oe_n, fwd_clk, lane_q}, 10'h3e0, "lanes driven");
		repeat (2 * PIX_N) @(negedge sys_clk);
		tx_req_n = 1'b1;
		wait_lock();
		check_in(lk_n, LOCK_N, LOCK_N + 10, "relock time");
		stream(10);
		$display("test tx power-down done");
		do_reset();
		wait_lock();
		check_in(lk_n, LOCK_N, LOCK_N + 10, "lock after reset");
		stream(10);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule : tb_lvds_pixel_link_serdes
